// [rtl/aarh_pkg.sv]
// constants and types for the async alert reply handler
// Summary of operation
// - reply carries result in byte 1, tag in bytes 2-3, code in 4-6.
// - tag stays allocated after a reply; reused until a new configuration.
// - replies whose type, subtype, information differ from the outstanding alert are dropped.
// - replies not matching both tag and code of the queue head are dropped.
// - a matching reply pops the head and lets the next queued alert go out.
// - hardware fault alert is 06h/03h/00h and puts the port in wrap mode.
// - other warning alerts of type 06h leave mode unchanged; subtype sets info meaning.
// - recovery exit types 10h-19h go privileged; 13h+ local, 14h+ remote status.
// - types BCh-BFh are master only and never originated by the node.
// - region membership alert is C0h with subtype 00h or 01h, mode unchanged.
// - without matching reply within 500 ms the alert is resent, indefinitely.
// - one alert awaits a reply per port; the rest wait in a port queue.
// - a reply for a port with nothing pending is dropped and flagged on RPL_DROP_O.
package aarh_pkg;
    localparam logic [7:0] CODE_REPLY = 8'h07;
    localparam logic [7:0] RES_OK = 8'h00;
    localparam logic [7:0] RES_BAD = 8'hFF;
    localparam logic [7:0] TYPE_WARN = 8'h06;
    localparam logic [7:0] SUB_FAN = 8'h01;
    localparam logic [7:0] SUB_HWFAULT = 8'h03;
    localparam logic [7:0] TYPE_REC_LO = 8'h10;
    localparam logic [7:0] TYPE_REC_LOCAL = 8'h13;
    localparam logic [7:0] TYPE_REC_REMOTE = 8'h14;
    localparam logic [7:0] TYPE_REC_HI = 8'h19;
    localparam logic [7:0] TYPE_RSV_LO = 8'hBC;
    localparam logic [7:0] TYPE_RSV_HI = 8'hBF;
    localparam logic [7:0] TYPE_REGION = 8'hC0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [2:0] REPLY_LAST = 3'h6;
    localparam logic [15:0] TAG_RST = 16'h0000;
    localparam longint CLK_HZ = 25000000;
    localparam longint RETRY_MS = 500;
    localparam int RETRY_CYC = int'(RETRY_MS * CLK_HZ / 1000);
    typedef enum logic [1:0] {
        MODE_UNCHANGED,
        MODE_WRAP,
        MODE_PRIV
    } aarh_mode_t;
    typedef enum logic [1:0] {
        RP_IDLE,
        RP_BODY,
        RP_SKIP
    } aarh_rp_t;
endpackage

// [rtl/aarh_top.sv]
// alert queue, transmit scheduler, retry timer and reply checker
`timescale 1ns/10ps
`default_nettype none
module aarh_top #(
    parameter int NUM_PORTS = 2,
    parameter int QDEPTH = 4,
    parameter int RETRY_CYCLES = aarh_pkg::RETRY_CYC,
    localparam int PW = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1
) (
    input wire logic CORE_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic CFG_VALID_I,
    input wire logic [PW-1:0] CFG_PORT_I,
    input wire logic [15:0] CFG_TAG_I,
    input wire logic ALERT_VALID_I,
    input wire logic [PW-1:0] ALERT_PORT_I,
    input wire logic [7:0] ALERT_TYPE_I,
    input wire logic [7:0] ALERT_SUB_I,
    input wire logic [7:0] ALERT_INFO_I,
    input wire logic [7:0] LOCAL_STATUS_I,
    input wire logic [7:0] REMOTE_STATUS_I,
    output logic ALERT_READY_O,
    output logic ALERT_REJECT_O,
    output logic MODE_VALID_O,
    output logic [PW-1:0] MODE_PORT_O,
    output var aarh_pkg::aarh_mode_t MODE_O,
    input wire logic RPL_VALID_I,
    input wire logic RPL_FIRST_I,
    input wire logic [7:0] RPL_BYTE_I,
    output logic RPL_DONE_O,
    output logic RPL_DROP_O,
    output logic [PW-1:0] RPL_PORT_O,
    output logic [7:0] RPL_RESULT_O,
    output logic TX_VALID_O,
    input wire logic TX_READY_I,
    output logic [PW-1:0] TX_PORT_O,
    output logic [15:0] TX_TAG_O,
    output logic [7:0] TX_TYPE_O,
    output logic [7:0] TX_SUB_O,
    output logic [7:0] TX_INFO_O,
    output logic [NUM_PORTS-1:0] PENDING_O
);
    import aarh_pkg::*;

    localparam int QW = $clog2(QDEPTH);
    localparam int CW = $clog2(QDEPTH + 1);
    localparam int TW = $clog2(RETRY_CYCLES + 1);

    // pointers wrap naturally, so both sizes must be powers of two
    if (NUM_PORTS < 2 || (NUM_PORTS & (NUM_PORTS - 1)) != 0) begin : g_chk_ports
        $error("NUM_PORTS must be a power of two, at least 2");
    end
    if (QDEPTH < 2 || (QDEPTH & (QDEPTH - 1)) != 0) begin : g_chk_depth
        $error("QDEPTH must be a power of two, at least 2");
    end
    if (RETRY_CYCLES < 2) begin : g_chk_retry
        $error("RETRY_CYCLES must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////
    // per-port state

    logic [23:0] q_mem [NUM_PORTS][QDEPTH];
    logic [QW-1:0] wptr_r [NUM_PORTS];
    logic [QW-1:0] rptr_r [NUM_PORTS];
    logic [CW-1:0] cnt_r [NUM_PORTS];
    logic [15:0] tag_r [NUM_PORTS];
    logic [15:0] head_tag_r [NUM_PORTS];
    logic [TW-1:0] tmr_r [NUM_PORTS];
    logic [NUM_PORTS-1:0] await_r;
    logic [NUM_PORTS-1:0] txd_r;
    logic [NUM_PORTS-1:0] pop;
    logic [NUM_PORTS-1:0] tmo;

    ////////////////////////////////////////////////////////////////////////
    // alert code shaping and acceptance

    logic [23:0] in_code;
    aarh_mode_t in_mode;
    logic in_bad;
    logic push;

    always_comb begin
        in_code = {ALERT_TYPE_I, ALERT_SUB_I, ALERT_INFO_I};
        in_mode = MODE_UNCHANGED;
        in_bad = (ALERT_TYPE_I >= TYPE_RSV_LO) && (ALERT_TYPE_I <= TYPE_RSV_HI);
        if (ALERT_TYPE_I == TYPE_WARN) begin
            if (ALERT_SUB_I == SUB_HWFAULT) begin
                in_code[7:0] = BYTE_ZERO;
                in_mode = MODE_WRAP;
            end else if (ALERT_SUB_I == SUB_FAN) begin
                in_code[7:0] = BYTE_ZERO;
            end
        end
        if (ALERT_TYPE_I >= TYPE_REC_LO && ALERT_TYPE_I <= TYPE_REC_HI) begin
            in_mode = MODE_PRIV;
            in_code[15:8] = (ALERT_TYPE_I >= TYPE_REC_LOCAL) ? LOCAL_STATUS_I : BYTE_ZERO;
            in_code[7:0] = (ALERT_TYPE_I >= TYPE_REC_REMOTE) ? REMOTE_STATUS_I : BYTE_ZERO;
        end
        if (ALERT_TYPE_I == TYPE_REGION) begin
            in_code[7:0] = BYTE_ZERO;
        end
    end

    // reserved codes are swallowed rather than stalled, so the source never hangs
    assign ALERT_READY_O = in_bad || (cnt_r[ALERT_PORT_I] != CW'(QDEPTH));
    assign push = ALERT_VALID_I && ALERT_READY_O && !in_bad;

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            ALERT_REJECT_O <= 1'b0;
            MODE_VALID_O <= 1'b0;
            MODE_PORT_O <= '0;
            MODE_O <= MODE_UNCHANGED;
        end else begin
            ALERT_REJECT_O <= ALERT_VALID_I && in_bad;
            MODE_VALID_O <= push && (in_mode != MODE_UNCHANGED);
            if (push) begin
                MODE_PORT_O <= ALERT_PORT_I;
                MODE_O <= in_mode;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reply parser

    aarh_rp_t rp_st_r;
    logic [2:0] rp_idx_r;
    logic [47:0] rp_buf_r;
    logic eval_r;

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            rp_st_r <= RP_IDLE;
            rp_idx_r <= 3'h0;
            eval_r <= 1'b0;
        end else begin
            eval_r <= 1'b0;
            if (RPL_VALID_I) begin
                if (RPL_FIRST_I) begin
                    rp_st_r <= (RPL_BYTE_I == CODE_REPLY) ? RP_BODY : RP_SKIP;
                    rp_idx_r <= 3'h1;
                end else begin
                    case (rp_st_r)
                        RP_BODY: begin
                            rp_idx_r <= rp_idx_r + 3'h1;
                            if (rp_idx_r == REPLY_LAST) begin
                                rp_st_r <= RP_IDLE;
                                eval_r <= 1'b1;
                            end
                        end
                        RP_IDLE, RP_SKIP: begin
                            rp_st_r <= rp_st_r;
                        end
                        default: begin
                            rp_st_r <= RP_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // result, tag high, tag low, type, subtype, information
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            rp_buf_r <= '0;
        end else if (RPL_VALID_I && !RPL_FIRST_I && rp_st_r == RP_BODY) begin
            rp_buf_r <= {rp_buf_r[39:0], RPL_BYTE_I};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reply check against queue heads

    logic hit;
    logic [PW-1:0] hit_port;

    always_comb begin
        hit = 1'b0;
        hit_port = '0;
        for (int p = NUM_PORTS - 1; p >= 0; p--) begin
            if (cnt_r[p] != '0 && txd_r[p] &&
                head_tag_r[p] == rp_buf_r[39:24] &&
                q_mem[p][rptr_r[p]] == rp_buf_r[23:0]) begin
                hit = 1'b1;
                hit_port = PW'(p);
            end
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
            pop[p] = eval_r && hit && (hit_port == PW'(p));
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            RPL_DONE_O <= 1'b0;
            RPL_DROP_O <= 1'b0;
            RPL_PORT_O <= '0;
            RPL_RESULT_O <= RES_OK;
        end else begin
            RPL_DONE_O <= eval_r && hit;
            RPL_DROP_O <= eval_r && !hit;
            if (eval_r && hit) begin
                RPL_PORT_O <= hit_port;
                RPL_RESULT_O <= rp_buf_r[47:40];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // queues and tags

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                wptr_r[p] <= '0;
                rptr_r[p] <= '0;
                cnt_r[p] <= '0;
            end
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (push && ALERT_PORT_I == PW'(p)) begin
                    wptr_r[p] <= wptr_r[p] + 1'b1;
                end
                if (pop[p]) begin
                    rptr_r[p] <= rptr_r[p] + 1'b1;
                end
                if ((push && ALERT_PORT_I == PW'(p)) && !pop[p]) begin
                    cnt_r[p] <= cnt_r[p] + 1'b1;
                end else if (!(push && ALERT_PORT_I == PW'(p)) && pop[p]) begin
                    cnt_r[p] <= cnt_r[p] - 1'b1;
                end
            end
        end
    end

    // payload only, no reset needed
    always_ff @(posedge CORE_CLK_I) begin
        if (push) begin
            q_mem[ALERT_PORT_I][wptr_r[ALERT_PORT_I]] <= in_code;
        end
    end

    // a reply never frees the tag; only configuration replaces it
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                tag_r[p] <= TAG_RST;
            end
        end else if (CFG_VALID_I) begin
            tag_r[CFG_PORT_I] <= CFG_TAG_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit scheduler, lowest port first

    logic ld;
    logic [PW-1:0] ld_port;

    always_comb begin
        ld = 1'b0;
        ld_port = '0;
        for (int p = NUM_PORTS - 1; p >= 0; p--) begin
            if (cnt_r[p] != '0 && !await_r[p] && !pop[p]) begin
                ld = !TX_VALID_O;
                ld_port = PW'(p);
            end
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            TX_VALID_O <= 1'b0;
            TX_PORT_O <= '0;
            TX_TAG_O <= TAG_RST;
            TX_TYPE_O <= BYTE_ZERO;
            TX_SUB_O <= BYTE_ZERO;
            TX_INFO_O <= BYTE_ZERO;
        end else if (ld) begin
            TX_VALID_O <= 1'b1;
            TX_PORT_O <= ld_port;
            TX_TAG_O <= tag_r[ld_port];
            {TX_TYPE_O, TX_SUB_O, TX_INFO_O} <= q_mem[ld_port][rptr_r[ld_port]];
        end else if (TX_VALID_O && TX_READY_I) begin
            TX_VALID_O <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outstanding flags and retry timers

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            await_r <= '0;
            txd_r <= '0;
            for (int p = 0; p < NUM_PORTS; p++) begin
                head_tag_r[p] <= TAG_RST;
                tmr_r[p] <= '0;
            end
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (pop[p] || tmo[p]) begin
                    await_r[p] <= 1'b0;
                end else if (ld && ld_port == PW'(p)) begin
                    await_r[p] <= 1'b1;
                    head_tag_r[p] <= tag_r[p];
                end
                // a stale send finishing as its entry pops must not mark the next one
                if (pop[p]) begin
                    txd_r[p] <= 1'b0;
                end else if (TX_VALID_O && TX_READY_I && TX_PORT_O == PW'(p)) begin
                    txd_r[p] <= 1'b1;
                end
                if (!await_r[p] || pop[p] || tmo[p]) begin
                    tmr_r[p] <= '0;
                end else if (!(TX_VALID_O && TX_PORT_O == PW'(p))) begin
                    tmr_r[p] <= tmr_r[p] + 1'b1;
                end
            end
        end
    end

    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            tmo[p] = await_r[p] && (tmr_r[p] == TW'(RETRY_CYCLES - 1));
            PENDING_O[p] = (cnt_r[p] != '0);
        end
    end
endmodule
`default_nettype wire

// [sim/aarh_props.sv]
// port assertions for the alert reply handler
`timescale 1ns/10ps
`default_nettype none
module aarh_props #(
    parameter int NUM_PORTS = 2,
    parameter int RETRY_CYCLES = aarh_pkg::RETRY_CYC
) (
    input wire logic CORE_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic ALERT_VALID_I,
    input wire logic ALERT_READY_O,
    input wire logic [7:0] ALERT_TYPE_I,
    input wire logic [7:0] ALERT_SUB_I,
    input wire logic ALERT_REJECT_O,
    input wire logic MODE_VALID_O,
    input wire aarh_pkg::aarh_mode_t MODE_O,
    input wire logic RPL_DONE_O,
    input wire logic [NUM_PORTS-1:0] PENDING_O,
    input wire logic TX_VALID_O,
    input wire logic TX_READY_I,
    input wire logic [15:0] TX_TAG_O,
    input wire logic [7:0] TX_TYPE_O
);
    import aarh_pkg::*;
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    logic acc;
    int unsigned idle_r;
    assign acc = ALERT_VALID_I && ALERT_READY_O;
    // idle span of the sender while something waits; cleared by any load
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I || TX_VALID_O || PENDING_O == '0) idle_r <= 0;
        else idle_r <= idle_r + 1;
    end
    a_reject_rsv: assert property (ALERT_VALID_I && ALERT_TYPE_I inside {[8'hBC:8'hBF]}
        |=> ALERT_REJECT_O) else $error("reserved type not rejected");
    a_tx_no_rsv: assert property (TX_VALID_O |-> !(TX_TYPE_O inside {[8'hBC:8'hBF]}))
        else $error("reserved type sent");
    a_hw_wrap: assert property (acc && ALERT_TYPE_I == 8'h06 && ALERT_SUB_I == 8'h03
        |=> MODE_VALID_O && MODE_O == MODE_WRAP) else $error("no wrap mode");
    a_recovery_priv: assert property (acc && ALERT_TYPE_I inside {[8'h10:8'h19]}
        |=> MODE_VALID_O && MODE_O == MODE_PRIV) else $error("no privileged mode");
    a_mode_kept: assert property (acc && (ALERT_TYPE_I == 8'h06 && ALERT_SUB_I != 8'h03
        || ALERT_TYPE_I == 8'hC0) |=> !MODE_VALID_O) else $error("mode changed");
    a_tx_hold: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O
        && $stable({TX_TAG_O, TX_TYPE_O})) else $error("alert not held");
    a_done_pend: assert property (RPL_DONE_O |-> $past(PENDING_O) != '0)
        else $error("reply taken with nothing pending");
    a_retry_bound: assert property (idle_r <= RETRY_CYCLES + 4)
        else $error("alert not resent in time");
endmodule
bind aarh_top aarh_props #(.NUM_PORTS(NUM_PORTS), .RETRY_CYCLES(RETRY_CYCLES)) u_props (.*);
`default_nettype wire

// [sim/aarh_master.sv]
// behavioural master: takes alerts, answers with reply messages
`timescale 1ns/10ps
`default_nettype none
module aarh_master (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tx_valid_i,
    input wire logic [15:0] tx_tag_i,
    input wire logic [23:0] tx_code_i,
    input wire logic [2:0] mode_i,
    input wire logic spur_i,
    output logic tx_ready_o,
    output logic rpl_valid_o,
    output logic rpl_first_o,
    output logic [7:0] rpl_byte_o
);
    // mode 0 good, 1 invalid field, 2 bad tag, 3 bad code, 4 silent, 5 wrong message code
    logic [7:0] msg [7];
    int idx;
    always @(posedge clk_i) begin
        if (rst_i) begin
            idx <= 7;
            tx_ready_o <= 1'b0;
            rpl_valid_o <= 1'b0;
            rpl_first_o <= 1'b0;
            rpl_byte_o <= 8'h00;
        end else if (idx < 7) begin
            rpl_valid_o <= 1'b1;
            rpl_first_o <= (idx == 0);
            rpl_byte_o <= msg[idx];
            idx <= idx + 1;
        end else begin
            rpl_valid_o <= 1'b0;
            rpl_first_o <= 1'b0;
            rpl_byte_o <= ~rpl_byte_o; // released line never holds the last byte
            tx_ready_o <= tx_valid_i && !tx_ready_o;
            if (tx_valid_i && tx_ready_o) begin
                msg[0] <= (mode_i == 3'h5) ? 8'h06 : 8'h07;
                msg[1] <= (mode_i == 3'h1) ? 8'hFF : 8'h00;
                {msg[2], msg[3]} <= tx_tag_i ^ {15'h0000, mode_i == 3'h2};
                {msg[4], msg[5], msg[6]} <= tx_code_i ^ {23'h000000, mode_i == 3'h3};
                if (mode_i != 3'h4) idx <= 0;
            end else if (spur_i) idx <= 0;
        end
    end
endmodule
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench for the alert reply handler
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import aarh_pkg::*;
    localparam int RC = 50;
    logic clk = 0, rst = 1, cfg_v = 0, cfg_p = 0, a_v = 0, a_p = 0, spur = 0;
    logic [7:0] a_t = 0, a_s = 0, a_i = 0, loc = 0, rem = 0, res, rb, tx_t, tx_s, tx_i;
    logic [15:0] cfg_tag = 0, tx_tag, cap_tag;
    logic [2:0] m_mode = 0;
    logic [1:0] pend;
    logic [23:0] cap_c;
    logic ready, tx_v, tx_rdy, rv, rf, done, drop, rp, tx_p, cap_p, mp;
    logic [15:0] tags [2];
    int tx_n = 0, dn_n = 0, dr_n = 0, mv_n = 0, errors = 0, tests_run = 0, seed = 83737;
    logic mvl;
    logic [15:0] tbl [14] = '{16'h0601, 16'h0602, 16'h0603, 16'h0604, 16'h0605, 16'h0606,
        16'h1000, 16'h127E, 16'h1300, 16'h1400, 16'h1900, 16'hC000, 16'hC001, 16'h1A00};
    aarh_top #(.NUM_PORTS(2), .QDEPTH(4), .RETRY_CYCLES(RC)) uut (
        .CORE_CLK_I(clk), .SYS_RST_I(rst), .CFG_VALID_I(cfg_v), .CFG_PORT_I(cfg_p),
        .CFG_TAG_I(cfg_tag), .ALERT_VALID_I(a_v), .ALERT_PORT_I(a_p), .ALERT_TYPE_I(a_t),
        .ALERT_SUB_I(a_s), .ALERT_INFO_I(a_i), .LOCAL_STATUS_I(loc), .REMOTE_STATUS_I(rem),
        .ALERT_READY_O(ready), .ALERT_REJECT_O(), .MODE_VALID_O(mvl), .MODE_PORT_O(mp),
        .MODE_O(), .RPL_VALID_I(rv), .RPL_FIRST_I(rf), .RPL_BYTE_I(rb), .RPL_DONE_O(done),
        .RPL_DROP_O(drop), .RPL_PORT_O(rp), .RPL_RESULT_O(res), .TX_VALID_O(tx_v),
        .TX_READY_I(tx_rdy), .TX_PORT_O(tx_p), .TX_TAG_O(tx_tag), .TX_TYPE_O(tx_t),
        .TX_SUB_O(tx_s), .TX_INFO_O(tx_i), .PENDING_O(pend));
    aarh_master u_master (.clk_i(clk), .rst_i(rst), .tx_valid_i(tx_v), .tx_tag_i(tx_tag),
        .tx_code_i({tx_t, tx_s, tx_i}), .mode_i(m_mode), .spur_i(spur), .tx_ready_o(tx_rdy),
        .rpl_valid_o(rv), .rpl_first_o(rf), .rpl_byte_o(rb));
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        if (tx_v && tx_rdy) begin
            tx_n++;
            cap_c <= {tx_t, tx_s, tx_i};
            cap_tag <= tx_tag;
            cap_p <= tx_p;
        end
        dn_n += int'(done === 1'b1);
        dr_n += int'(drop === 1'b1);
        mv_n += int'(mvl === 1'b1);
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] exp_code(input logic [7:0] t, s, i, l, r);
        if (t == 8'h06 && (s == 8'h01 || s == 8'h03)) return {t, s, 8'h00};
        if (t >= 8'h10 && t <= 8'h19) return {t, t >= 8'h13 ? l : 8'h00, t >= 8'h14 ? r : 8'h00};
        if (t == 8'hC0) return {t, s, 8'h00};
        return {t, s, i};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic push(input logic p, input logic [7:0] t, s, i, l, r);
        @(posedge clk);
        a_v <= 1'b1;
        a_p <= p;
        a_t <= t;
        a_s <= s;
        a_i <= i;
        loc <= l;
        rem <= r;
        @(negedge clk);
        while (ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        a_v <= 1'b0;
    endtask
    // bounded wait on the event counters; running out is a mismatch
    task automatic await(input int tx, dn, dr, lim);
        int k;
        k = 0;
        while ((tx_n < tx || dn_n < dn || dr_n < dr) && k < lim) begin
            @(negedge clk);
            k++;
        end
        if (k >= lim) begin
            errors++;
            $display("ERROR t=%0t wait ran out", $time);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic p;
        logic [7:0] inf, lv, rmv;
        int n0, d0, r0, m0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int q = 0; q < 2; q++) begin
            @(posedge clk);
            tags[q] = 16'($random(seed));
            cfg_v <= 1'b1;
            cfg_p <= 1'(q);
            cfg_tag <= tags[q];
            @(posedge clk);
            cfg_v <= 1'b0;
        end
        for (int i = 0; i < 14; i++) begin
            p = 1'($random(seed));
            inf = 8'($random(seed));
            lv = 8'($random(seed));
            rmv = 8'($random(seed));
            m_mode <= 3'(i % 2);
            {n0, d0, m0} = {tx_n, dn_n, mv_n};
            push(p, tbl[i][15:8], tbl[i][7:0], inf, lv, rmv);
            await(n0 + 1, d0 + 1, 0, 200);
            @(negedge clk);
            chk(cap_c, exp_code(tbl[i][15:8], tbl[i][7:0], inf, lv, rmv));
            chk({cap_p, cap_tag}, {p, tags[p]});
            chk({rp, res}, {p, (i % 2) ? 8'hFF : 8'h00});
            chk(pend, 0);
            chk(mp, p);
            chk(mv_n - m0, (tbl[i] == 16'h0603 || tbl[i][15:12] == 4'h1 && i < 11) ? 1 : 0);
        end
        m_mode <= 3'h4;
        {n0, d0, r0} = {tx_n, dn_n, dr_n};
        push(0, 8'h06, 8'h03, 8'h99, 8'h00, 8'h00);
        push(0, 8'hC0, 8'h01, 8'h5A, 8'h00, 8'h00);
        await(n0 + 1, 0, 0, 50);
        repeat (RC - 4) @(negedge clk);
        chk(tx_n, n0 + 1);
        await(n0 + 2, 0, 0, 20);
        chk(cap_c, 24'h060300);
        m_mode <= 3'h2;
        await(0, 0, r0 + 1, RC * 2);
        m_mode <= 3'h3;
        await(0, 0, r0 + 2, RC * 2);
        chk(dn_n, d0);
        m_mode <= 3'h5;
        n0 = tx_n;
        await(n0 + 1, 0, 0, RC * 2);
        repeat (12) @(negedge clk);
        chk({8'(dr_n - r0), 8'(dn_n - d0)}, 16'h0200);
        m_mode <= 3'h0;
        await(0, d0 + 2, 0, RC * 3);
        chk(cap_c, 24'hC00100);
        @(posedge clk);
        spur <= 1'b1;
        @(posedge clk);
        spur <= 1'b0;
        await(0, 0, r0 + 3, 30);
        chk({pend, 8'(dn_n - d0)}, 2);
        n0 = tx_n;
        for (int t = 8'hBC; t <= 8'hBF; t++) push(1, 8'(t), 8'h00, 8'h00, 8'h00, 8'h00);
        repeat (5) @(negedge clk);
        chk({pend, 8'(tx_n - n0)}, 0);
        m_mode <= 3'h4;
        push(1, 8'h06, 8'h05, 8'h21, 8'h00, 8'h00);
        await(n0 + 1, 0, 0, 50);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        n0 = tx_n;
        repeat (RC + 10) @(negedge clk);
        chk({pend, 8'(tx_n - n0)}, 0);
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("ERROR t=%0t watchdog expired", $time);
        wrap_up();
    end
endmodule
`default_nettype wire
